//--- pcm_slot_pkg.sv
// Constants for the PCM time slot and capture pin control block.
// Assumes a 200 MHz mclk_i, AHB-Lite register access, bit clock and frame sync from pins.
// Operation
// R1: Left offset is nine low bits plus bit 9
// R2: Right offset is nine low bits plus bit 9
// R3: Left high bit lives in the shared control register
// R4: Offsets apply only with slot enable and PCM
// R5: Late tri-state releases pin after LSB end
// R6: Short select forces 8-bit words
// R7: Driver enable 1 drives pin, 0 floats
// R8: Resistor on with polarity 1 pulls up
// R9: Resistor on with polarity 0 pulls down
// R10: Resistor off applies no pull at all
// R11: Control register resets to 0x020
// R12: Both low slot registers reset to zero
// R13: Revision register is read-only
// R14: Host keeps left and right slots disjoint
// R15: Offsets count bit clocks from frame sync
`default_nettype none
package pcm_slot_pkg;
   localparam int REG_W = 9;
   localparam int CNT_W = 11;
   localparam int WORD_BITS = 16;
   localparam int SHORT_BITS = 8;
   localparam int FIFO_DEPTH = 4;
   // Printed offsets are register indices; the byte address is four times the index
   localparam logic [7:0] LEFT_SLOT_IDX = 8'h3B;
   localparam logic [7:0] CONTROL_IDX = 8'h3C;
   localparam logic [7:0] RIGHT_SLOT_IDX = 8'h3D;
   localparam logic [7:0] VERSION_IDX = 8'h3E;
   localparam int SLOT_EN_BIT = 8;
   localparam int LATE_HIZ_BIT = 7;
   localparam int SHORT_BIT = 6;
   localparam int DRV_EN_BIT = 5;
   localparam int RES_EN_BIT = 4;
   localparam int RES_POL_BIT = 3;
   localparam int RIGHT_MSB_BIT = 1;
   localparam int LEFT_MSB_BIT = 0;
   localparam logic [8:0] CONTROL_RESET = 9'h020;
   localparam logic [8:0] CONTROL_WMASK = 9'h1FB;
   localparam logic [8:0] SLOT_RESET = 9'h000;
   localparam logic [4:0] LONG_LEN = 5'h10;
   localparam logic [4:0] SHORT_LEN = 5'h08;
endpackage
`default_nettype wire

//--- pcm_slot_ctrl.sv
// PCM capture port with time slot offsets, pin control and a small sample FIFO.
// Assumes bclk_i and fsync_i are asynchronous pins; pcm_mode_i and samples share mclk_i.
`default_nettype none
module pcm_word_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 4
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic ready_q, ready_d, valid_q, valid_d;
   logic push, pop;

   always_comb begin
      push = in_valid_i && ready_q;
      pop = out_ready_i && valid_q;
      mem_d = mem_q;
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (push) begin
         mem_d[wr_q] = in_data_i;
         wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      if (push && !pop) begin
         cnt_d = cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_d = cnt_q - 1'b1;
      end
      ready_d = (cnt_d != (AW+1)'(DEPTH));
      valid_d = (cnt_d != '0);
   end

   // Storage carries no reset; only pointers and flags need a defined value
   always_ff @(posedge mclk_i) begin
      mem_q <= mem_d;
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         ready_q <= 1'b1;
         valid_q <= 1'b0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
         ready_q <= ready_d;
         valid_q <= valid_d;
      end
   end

   assign in_ready_o = ready_q;
   assign out_valid_o = valid_q;
   assign out_data_o = mem_q[rd_q];
endmodule

module pcm_slot_ctrl #(
   parameter logic [8:0] SILICON_VERSION = 9'h0A5 // Arbitrary value
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic pcm_mode_i,
   input wire logic bclk_i,
   input wire logic fsync_i,
   input wire logic sample_valid_i,
   input wire logic [31:0] sample_i,
   output logic sample_ready_o,
   output logic capture_data_o,
   output logic capture_data_oe_o,
   output logic pull_up_en_o,
   output logic pull_down_en_o
);
   logic [8:0] left_q, left_d, right_q, right_d, ctl_q, ctl_d;
   logic ap_wr_q, ap_wr_d, rd_q, rd_d, ready_q;
   logic [7:0] idx_q, idx_d;
   logic [31:0] hrdata_q, hrdata_d;
   logic [9:0] left_slot_offset, right_slot_offset;
   logic addr_ok;

   // Register file
   always_comb begin
      left_d = left_q;
      right_d = right_q;
      ctl_d = ctl_q;
      ap_wr_d = ap_wr_q;
      rd_d = rd_q;
      idx_d = idx_q;
      hrdata_d = hrdata_q;
      addr_ok = hsel_i && htrans_i[1];
      if (ap_wr_q) begin
         case (idx_q)
            pcm_slot_pkg::LEFT_SLOT_IDX: left_d = hwdata_i[8:0];
            pcm_slot_pkg::RIGHT_SLOT_IDX: right_d = hwdata_i[8:0];
            pcm_slot_pkg::CONTROL_IDX: ctl_d = hwdata_i[8:0] & pcm_slot_pkg::CONTROL_WMASK;
            default: ; // [R13]
         endcase
      end
      if (hready_i) begin
         ap_wr_d = addr_ok && hwrite_i;
         rd_d = addr_ok && !hwrite_i;
         idx_d = haddr_i[9:2];
         // Read mux looks at next values so a read right after a write sees it
         if (addr_ok && !hwrite_i) begin
            case (haddr_i[9:2])
               pcm_slot_pkg::LEFT_SLOT_IDX: hrdata_d = {23'h000000, left_d};
               pcm_slot_pkg::RIGHT_SLOT_IDX: hrdata_d = {23'h000000, right_d};
               pcm_slot_pkg::CONTROL_IDX: hrdata_d = {23'h000000, ctl_d};
               pcm_slot_pkg::VERSION_IDX: hrdata_d = {23'h000000, SILICON_VERSION}; // [R13]
               default: hrdata_d = 32'h00000000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         left_q <= pcm_slot_pkg::SLOT_RESET; // [R12]
         right_q <= pcm_slot_pkg::SLOT_RESET; // [R12]
         ctl_q <= pcm_slot_pkg::CONTROL_RESET; // [R11]
         ap_wr_q <= 1'b0;
         rd_q <= 1'b0;
         idx_q <= 8'h00;
         hrdata_q <= 32'h00000000;
         ready_q <= 1'b1;
      end else begin
         left_q <= left_d;
         right_q <= right_d;
         ctl_q <= ctl_d;
         ap_wr_q <= ap_wr_d;
         rd_q <= rd_d;
         idx_q <= idx_d;
         hrdata_q <= hrdata_d;
         ready_q <= 1'b1;
      end
   end

   assign left_slot_offset = {ctl_q[pcm_slot_pkg::LEFT_MSB_BIT], left_q}; // [R1] [R3]
   assign right_slot_offset = {ctl_q[pcm_slot_pkg::RIGHT_MSB_BIT], right_q}; // [R2]

   // Pin synchronisers and serial timing
   localparam int CW = pcm_slot_pkg::CNT_W;
   logic bclk_m_q, bclk_s_q, bclk_p_q, fs_m_q, fs_s_q, fs_p_q, fs_p_d, pend_q, pend_d;
   logic bclk_rise, bclk_fall, slot_act, fifo_valid, pop;
   logic [31:0] fifo_data, cur_q, cur_d;
   logic [15:0] sh_q, sh_d;
   logic [4:0] bits_q, bits_d, wlen;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [9:0] lstart, rstart;
   logic pin_q, pin_d, oe_q, oe_d, pu_q, pu_d, pd_q, pd_d;

   pcm_word_fifo #(
      .WIDTH(32),
      .DEPTH(pcm_slot_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .in_valid_i(sample_valid_i),
      .in_data_i(sample_i),
      .in_ready_o(sample_ready_o),
      .out_valid_o(fifo_valid),
      .out_data_o(fifo_data),
      .out_ready_i(pop)
   );

   always_comb begin
      bclk_rise = bclk_s_q && !bclk_p_q;
      bclk_fall = !bclk_s_q && bclk_p_q;
      slot_act = ctl_q[pcm_slot_pkg::SLOT_EN_BIT] && pcm_mode_i; // [R4]
      wlen = ctl_q[pcm_slot_pkg::SHORT_BIT] ? pcm_slot_pkg::SHORT_LEN
                                            : pcm_slot_pkg::LONG_LEN; // [R6]
      lstart = slot_act ? left_slot_offset : 10'h000; // [R4]
      rstart = slot_act ? right_slot_offset : {5'h00, wlen};
      pend_d = pend_q;
      fs_p_d = bclk_rise ? fs_s_q : fs_p_q;
      cnt_d = cnt_q;
      cur_d = cur_q;
      sh_d = sh_q;
      bits_d = bits_q;
      pin_d = pin_q;
      pop = 1'b0;
      if (bclk_rise && fs_s_q && !fs_p_q) begin
         pend_d = 1'b1;
      end
      if (bclk_fall) begin
         // Count bit times from the frame sync, saturating past the longest offset
         if (pend_q) begin
            cnt_d = '0; // [R15]
            pend_d = 1'b0;
            pop = fifo_valid;
            cur_d = fifo_valid ? fifo_data : 32'h00000000;
         end else if (cnt_q != {CW{1'b1}}) begin
            cnt_d = cnt_q + 1'b1; // [R15]
         end
         if (cnt_d == {1'b0, lstart}) begin
            sh_d = cur_d[31:16] << 1;
            pin_d = cur_d[31];
            bits_d = wlen;
         end else if (cnt_d == {1'b0, rstart}) begin
            sh_d = cur_d[15:0] << 1;
            pin_d = cur_d[15];
            bits_d = wlen;
         end else if (bits_q != 5'h00) begin
            pin_d = sh_q[15];
            sh_d = sh_q << 1;
            bits_d = bits_q - 1'b1;
         end
      end
      // Short words send the upper byte of each 16-bit half, then its next bit on the ninth bit time unless another word starts
      oe_d = ctl_q[pcm_slot_pkg::DRV_EN_BIT] && // [R7]
             (!ctl_q[pcm_slot_pkg::LATE_HIZ_BIT] || bits_d != 5'h00); // [R5]
      pu_d = ctl_q[pcm_slot_pkg::RES_EN_BIT] && ctl_q[pcm_slot_pkg::RES_POL_BIT]; // [R8] [R10]
      pd_d = ctl_q[pcm_slot_pkg::RES_EN_BIT] && !ctl_q[pcm_slot_pkg::RES_POL_BIT]; // [R9] [R10]
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         bclk_m_q <= 1'b0;
         bclk_s_q <= 1'b0;
         bclk_p_q <= 1'b0;
         fs_m_q <= 1'b0;
         fs_s_q <= 1'b0;
         fs_p_q <= 1'b0;
         pend_q <= 1'b0;
         cnt_q <= {CW{1'b1}};
         cur_q <= 32'h00000000;
         sh_q <= 16'h0000;
         bits_q <= 5'h00;
         pin_q <= 1'b0;
         oe_q <= 1'b0;
         pu_q <= 1'b0;
         pd_q <= 1'b0;
      end else begin
         bclk_m_q <= bclk_i;
         bclk_s_q <= bclk_m_q;
         bclk_p_q <= bclk_s_q;
         fs_m_q <= fsync_i;
         fs_s_q <= fs_m_q;
         fs_p_q <= fs_p_d;
         pend_q <= pend_d;
         cnt_q <= cnt_d;
         cur_q <= cur_d;
         sh_q <= sh_d;
         bits_q <= bits_d;
         pin_q <= pin_d;
         oe_q <= oe_d;
         pu_q <= pu_d;
         pd_q <= pd_d;
      end
   end

   assign hrdata_o = hrdata_q;
   assign hreadyout_o = ready_q;
   assign hresp_o = 1'b0;
   assign capture_data_o = pin_q;
   assign capture_data_oe_o = oe_q;
   assign pull_up_en_o = pu_q;
   assign pull_down_en_o = pd_q;

   AST_LEFT_MSB_FROM_CONTROL: assert property (@(posedge mclk_i) disable iff (rst_i) // [R3]
      ap_wr_q && idx_q == pcm_slot_pkg::CONTROL_IDX |=>
         left_slot_offset[9] == $past(hwdata_i[0]) && right_slot_offset[9] == $past(hwdata_i[1]))
      else $error("Offset high bits not taken from control write");
   AST_LEFT_LOW_BITS: assert property (@(posedge mclk_i) disable iff (rst_i) // [R1]
      ap_wr_q && idx_q == pcm_slot_pkg::LEFT_SLOT_IDX |=>
         left_slot_offset[8:0] == $past(hwdata_i[8:0]))
      else $error("Left offset low bits not updated");
   AST_RIGHT_SLOT_LOAD: assert property (@(posedge mclk_i) disable iff (rst_i) // [R2]
      bclk_fall && slot_act && !pend_q && cnt_q != {CW{1'b1}}
         && cnt_q + 1'b1 == {1'b0, right_slot_offset}
         && cnt_q + 1'b1 != {1'b0, left_slot_offset} |=> bits_q == $past(wlen))
      else $error("Right word did not start at its offset");
   AST_PLAIN_MODE_START: assert property (@(posedge mclk_i) disable iff (rst_i) // [R4]
      bclk_fall && pend_q && !slot_act |=> bits_q == $past(wlen) && pin_q == $past(cur_d[31]))
      else $error("Left word did not start at frame start outside slot mode");
   AST_LATE_HIZ: assert property (@(posedge mclk_i) disable iff (rst_i) // [R5]
      ctl_q[7] && bits_q == 5'h01 && bclk_fall && !pend_q && cnt_q + 1'b1 != {1'b0, rstart}
         && cnt_q + 1'b1 != {1'b0, lstart} ##0 $stable(ctl_q) |=> !capture_data_oe_o)
      else $error("Pin not released after last bit");
   AST_SHORT_WORD: assert property (@(posedge mclk_i) disable iff (rst_i) // [R6]
      ctl_q[6] && bclk_fall && pend_q && lstart == 10'h000 |=> bits_q == 5'h08)
      else $error("Short word length not applied");
   AST_DRIVER_OFF: assert property (@(posedge mclk_i) disable iff (rst_i) // [R7]
      !ctl_q[5] |=> !capture_data_oe_o)
      else $error("Pin driven with driver disabled");
   AST_PULLS: assert property (@(posedge mclk_i) disable iff (rst_i) // [R8] [R9] [R10]
      1'b1 |=> pull_up_en_o == $past(ctl_q[4] && ctl_q[3]) && !(pull_up_en_o && pull_down_en_o)
         && pull_down_en_o == $past(ctl_q[4] && !ctl_q[3]))
      else $error("Pull resistor select wrong");
   AST_RESET_VALUES: assert property (@(posedge mclk_i) // [R11] [R12]
      rst_i |=> ctl_q == 9'h020 && left_q == 9'h000 && right_q == 9'h000)
      else $error("Register reset values wrong");
   AST_VERSION_READ: assert property (@(posedge mclk_i) disable iff (rst_i) // [R13]
      rd_q && idx_q == pcm_slot_pkg::VERSION_IDX |-> hrdata_o == {23'h000000, SILICON_VERSION})
      else $error("Revision readout changed");
   AST_COUNT_STEP: assert property (@(posedge mclk_i) disable iff (rst_i) // [R15]
      bclk_fall && !pend_q && cnt_q != {CW{1'b1}} |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("Bit time counter did not advance");
endmodule
`default_nettype wire

//--- pcm_host_model.sv
// Behavioural host PCM controller: makes bit clock and frame sync, samples capture pin.
// Assumes the bench calls frame() between register accesses; bit clock stands still otherwise.
`default_nettype none
module pcm_host_model (
   output logic bclk_o,
   output logic fsync_o,
   input wire logic data_i,
   input wire logic oe_i,
   input wire logic pu_i,
   input wire logic pd_i
);
   timeunit 1ns;
   timeprecision 1ps;
   logic cap_bit [0:639];
   logic cap_oe [0:639];
   logic pin = 1'b0;
   initial begin
      bclk_o = 1'b0;
      fsync_o = 1'b0;
   end
   // Half period of 40 ns leaves the synchronised pin time to settle before the rise
   task automatic frame(input int n);
      for (int i = 0; i <= n + 1; i++) begin
         fsync_o = (i == 1);
         #40;
         bclk_o = 1'b1;
         // Floating pin shows the inverse of the last level, never a stale copy
         pin = oe_i ? data_i : (pu_i ? 1'b1 : (pd_i ? 1'b0 : ~pin));
         if (i >= 2) begin
            cap_bit[i-2] = pin;
            cap_oe[i-2] = oe_i;
         end
         #40;
         bclk_o = 1'b0;
      end
      fsync_o = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking bench for the PCM slot and capture pin control block.
// Assumes the host model above; registers reached over a single-master AHB-Lite bus.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'b0;
   logic rst_i = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, pcm_mode = 1'b1, svalid = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, sdata = 32'h0, rd, seed = 32'hD71388BE;
   logic [31:0] hrdata;
   logic hready, hresp, sready, cdata, coe, pu, pd, bclk, fsync;
   logic [31:0] smp [4];
   logic [8:0] pc [4] = '{9'h038, 9'h030, 9'h028, 9'h018};
   logic [2:0] pe [4] = '{3'h6, 3'h5, 3'h4, 3'h2};
   int mismatches = 0;
   int cmp_count = 0;
   always #2.5 mclk_i = ~mclk_i;
   pcm_slot_ctrl #(.SILICON_VERSION(9'h15A)) uut ( // Version value is arbitrary
      .mclk_i(mclk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hready_i(hready), .hwdata_i(hwdata),
      .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .pcm_mode_i(pcm_mode),
      .bclk_i(bclk), .fsync_i(fsync), .sample_valid_i(svalid), .sample_i(sdata),
      .sample_ready_o(sready), .capture_data_o(cdata), .capture_data_oe_o(coe),
      .pull_up_en_o(pu), .pull_down_en_o(pd));
   pcm_host_model host (.bclk_o(bclk), .fsync_o(fsync), .data_i(cdata), .oe_i(coe),
      .pu_i(pu), .pd_i(pd));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] ba(input logic [7:0] idx);
      return {22'h0, idx, 2'b00};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge mclk_i);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge mclk_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [8:0] d);
      ahb(1'b1, ba(idx), {23'h0, d});
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [8:0] exp);
      ahb(1'b0, ba(idx), 32'h0);
      check(rd, {23'h0, exp});
      check({31'h0, hresp}, 32'h0);
   endtask
   // Compares both channel words, MSB first, and that the pin was driven meanwhile
   task automatic chk(input logic [31:0] s, input int ls, input int rs, input int n);
      for (int j = 0; j < n; j++) begin
         check({31'h0, host.cap_bit[ls+j]}, {31'h0, s[31-j]});
         check({31'h0, host.cap_bit[rs+j]}, {31'h0, s[15-j]});
         check({30'h0, host.cap_oe[ls+j], host.cap_oe[rs+j]}, 32'h3);
      end
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #150000;
      mismatches++;
      results;
   end
   initial begin
      repeat (4) @(posedge mclk_i);
      rst_i <= 1'b0;
      rdc(pcm_slot_pkg::LEFT_SLOT_IDX, 9'h000);
      rdc(pcm_slot_pkg::CONTROL_IDX, 9'h020);
      rdc(pcm_slot_pkg::RIGHT_SLOT_IDX, 9'h000);
      wr(pcm_slot_pkg::VERSION_IDX, 9'h000);
      rdc(pcm_slot_pkg::VERSION_IDX, 9'h15A);
      rdc(8'h3F, 9'h000);
      wr(pcm_slot_pkg::CONTROL_IDX, 9'h1FF);
      rdc(pcm_slot_pkg::CONTROL_IDX, 9'h1FB);
      for (int i = 0; i < 4; i++) begin
         wr(pcm_slot_pkg::CONTROL_IDX, pc[i]);
         repeat (3) @(posedge mclk_i);
         check({29'h0, coe, pu, pd}, {29'h0, pe[i]});
      end
      wr(pcm_slot_pkg::CONTROL_IDX, 9'h020);
      $display("test registers and pins done");
      // Four words fill the FIFO; ready must then stay low until a frame pops one
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         smp[i] = seed;
         svalid <= 1'b1;
         sdata <= seed;
         do @(posedge mclk_i); while (sready !== 1'b1);
      end
      svalid <= 1'b0;
      @(posedge mclk_i);
      check({31'h0, sready}, 32'h0);
      $display("test fifo fill done");
      host.frame(40);
      chk(smp[0], 0, 16, 16);
      // Offsets kept disjoint by the host
      wr(pcm_slot_pkg::LEFT_SLOT_IDX, 9'h005);
      wr(pcm_slot_pkg::RIGHT_SLOT_IDX, 9'h01E);
      wr(pcm_slot_pkg::CONTROL_IDX, 9'h1A0);
      host.frame(48);
      chk(smp[1], 5, 30, 16);
      check({30'h0, host.cap_oe[4], host.cap_oe[21]}, 32'h0);
      pcm_mode <= 1'b0;
      wr(pcm_slot_pkg::CONTROL_IDX, 9'h160);
      host.frame(24);
      chk(smp[2], 0, 8, 8);
      pcm_mode <= 1'b1;
      wr(pcm_slot_pkg::LEFT_SLOT_IDX, 9'h01E);
      wr(pcm_slot_pkg::RIGHT_SLOT_IDX, 9'h003);
      wr(pcm_slot_pkg::CONTROL_IDX, 9'h123);
      host.frame(560);
      chk(smp[3], 542, 515, 16);
      $display("test serial frames done");
      results;
   end
endmodule
`default_nettype wire
